// ### common/aneg_regs_pkg.sv
// constants and carrier types for the copper base-page register bank
// What this block does
// - writes to both 10BASE-T advertise bits wait for reset, restart, power-up or link loss
// - forced 1000 with negotiation off still negotiates, advertising 1000BASE-T at forced duplex
// - in forced 1000, 10/100 advertise bits 8:5 and gigabit control bits are ignored
// - hardware reset loads both 10BASE-T advertise bits from strap bit 1
// - selector field is read-write, resets to 00001, survives software reset
// - partner ability is read-only, mirrors received code word, clears on any reset except a software reset that meets an arriving page
// - partner bit 15 shows partner next-page capability
// - partner bit 14 shows partner acknowledged our code word
// - partner bit 13 shows partner detected a remote fault
// - partner bit 11 asymmetric pause request, bit 10 pause capability
// - partner bits 9 to 5 show T4, TX full, TX half, 10 full, 10 half
// - partner bit 12 reflects received code word bit 12 as is
package aneg_regs_pkg;
   // register indexes; byte address is four times the index
   localparam logic [5:0] IDX_CTRL = 6'h00;
   localparam logic [5:0] IDX_STAT = 6'h01;
   localparam logic [5:0] IDX_ADV = 6'h04;
   localparam logic [5:0] IDX_PART = 6'h05;
   // control register fields
   localparam int CTRL_SWRST_BIT = 15;
   localparam int CTRL_SPD_LSB_BIT = 13;
   localparam int CTRL_ANEG_EN_BIT = 12;
   localparam int CTRL_PD_BIT = 11;
   localparam int CTRL_RESTART_BIT = 9;
   localparam int CTRL_DUPLEX_BIT = 8;
   localparam int CTRL_SPD_MSB_BIT = 6;
   // status register fields
   localparam int STAT_LINK_BIT = 2;
   // advertisement fields
   localparam int ADV_10FD_BIT = 6;
   localparam int ADV_10HD_BIT = 5;
   localparam int ADV_TECH_HI = 8;
   localparam int ADV_TECH_LO = 5;
   localparam int SEL_HI = 4;
   localparam int STRAP_10_BIT = 1;
   // reset values
   localparam logic [4:0] SEL_RESET = 5'h01;
   localparam logic [15:0] PART_RESET = 16'h0000;
   localparam logic ANEG_EN_RESET = 1'b1;
   typedef struct packed {
      logic aneg_en;
      logic power_down;
      logic duplex;
      logic speed_msb;
      logic speed_lsb;
   } ctrl_t;
   typedef struct packed {
      logic [15:0] page;
      logic gig_fd;
      logic gig_hd;
      logic aneg_on;
   } adv_out_t;
endpackage

// ### hdl/copper_aneg_base_page_regs.sv
// base-page advertisement and partner ability registers on a wishbone slave
`timescale 1ns/100ps
module copper_aneg_base_page_regs (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   input wire logic [1:0] negotiation_config_strap_i,
   input wire logic link_up_i,
   input wire logic page_valid_i,
   input wire logic [15:0] rx_page_i,
   output aneg_regs_pkg::adv_out_t adv_o
);

   aneg_regs_pkg::ctrl_t ctrl;
   aneg_regs_pkg::ctrl_t next_ctrl;
   logic [1:0] pend10;
   logic [1:0] next_pend10;
   logic [1:0] act10;
   logic [1:0] next_act10;
   logic [4:0] selector;
   logic [4:0] next_selector;
   logic [15:0] partner;
   logic [15:0] next_partner;
   logic link_q;
   logic next_link_q;
   logic next_ack;
   logic [31:0] next_dat;
   aneg_regs_pkg::adv_out_t next_adv;
   logic [1:0] strap_meta;
   logic [1:0] strap_sync;

   logic req;
   logic wr;
   logic [5:0] idx;
   logic [15:0] lane_mask;
   logic [15:0] ctrl_word;
   logic [15:0] ctrl_new;
   logic [15:0] adv_word;
   logic [15:0] rd_word;
   logic sw_rst_evt;
   logic restart_evt;
   logic pd_exit_evt;
   logic link_lost_evt;
   logic apply;
   logic forced;

   // strap pin crosses in through two flops, no reset so it is ready at release
   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         strap_meta <= negotiation_config_strap_i;
         strap_sync <= strap_meta;
      end
   end

   always_comb begin
      ctrl_word = 16'h0000;
      ctrl_word[aneg_regs_pkg::CTRL_ANEG_EN_BIT] = ctrl.aneg_en;
      ctrl_word[aneg_regs_pkg::CTRL_PD_BIT] = ctrl.power_down;
      ctrl_word[aneg_regs_pkg::CTRL_DUPLEX_BIT] = ctrl.duplex;
      ctrl_word[aneg_regs_pkg::CTRL_SPD_MSB_BIT] = ctrl.speed_msb;
      ctrl_word[aneg_regs_pkg::CTRL_SPD_LSB_BIT] = ctrl.speed_lsb;
      adv_word = {9'h000, pend10, selector};
   end

   always_comb begin
      req = cyc_i && stb_i;
      wr = req && ack_o && we_i;
      idx = adr_i[7:2];
      lane_mask = {{8{sel_i[1]}}, {8{sel_i[0]}}};
      ctrl_new = (ctrl_word & ~lane_mask) | (dat_i[15:0] & lane_mask);
      unique case (idx)
         aneg_regs_pkg::IDX_CTRL: rd_word = ctrl_word;
         aneg_regs_pkg::IDX_STAT: rd_word = 16'(link_q) << aneg_regs_pkg::STAT_LINK_BIT;
         aneg_regs_pkg::IDX_ADV: rd_word = adv_word;
         aneg_regs_pkg::IDX_PART: rd_word = partner;
         default: rd_word = 16'h0000;
      endcase
   end

   // events that release a pending advertisement write
   always_comb begin
      sw_rst_evt = wr && idx == aneg_regs_pkg::IDX_CTRL && sel_i[1]
         && dat_i[aneg_regs_pkg::CTRL_SWRST_BIT];
      restart_evt = wr && idx == aneg_regs_pkg::IDX_CTRL && sel_i[1]
         && dat_i[aneg_regs_pkg::CTRL_RESTART_BIT];
      pd_exit_evt = wr && idx == aneg_regs_pkg::IDX_CTRL && sel_i[1] && ctrl.power_down
         && !dat_i[aneg_regs_pkg::CTRL_PD_BIT];
      link_lost_evt = link_q && !link_up_i;
      apply = sw_rst_evt || restart_evt || pd_exit_evt || link_lost_evt;
      forced = !ctrl.aneg_en && ctrl.speed_msb && !ctrl.speed_lsb;
   end

   always_comb begin
      next_ctrl = ctrl;
      next_pend10 = pend10;
      next_act10 = act10;
      next_selector = selector;
      next_partner = partner;
      next_link_q = link_up_i;
      next_ack = req && !ack_o;
      next_dat = dat_o;
      if (req && !ack_o) begin
         next_dat = {16'h0000, rd_word};
      end
      if (wr && idx == aneg_regs_pkg::IDX_CTRL) begin
         next_ctrl.aneg_en = ctrl_new[aneg_regs_pkg::CTRL_ANEG_EN_BIT];
         next_ctrl.power_down = ctrl_new[aneg_regs_pkg::CTRL_PD_BIT];
         next_ctrl.duplex = ctrl_new[aneg_regs_pkg::CTRL_DUPLEX_BIT];
         next_ctrl.speed_msb = ctrl_new[aneg_regs_pkg::CTRL_SPD_MSB_BIT];
         next_ctrl.speed_lsb = ctrl_new[aneg_regs_pkg::CTRL_SPD_LSB_BIT];
      end
      if (apply) begin
         next_act10 = pend10;
      end
      if (wr && idx == aneg_regs_pkg::IDX_ADV && sel_i[0]) begin
         next_pend10 = {dat_i[aneg_regs_pkg::ADV_10FD_BIT],
            dat_i[aneg_regs_pkg::ADV_10HD_BIT]};
         next_selector = dat_i[aneg_regs_pkg::SEL_HI:0];
      end
      // software reset leaves the selector alone
      if (sw_rst_evt) begin
         next_partner = aneg_regs_pkg::PART_RESET;
      end
      // a page arriving with the reset is kept
      if (page_valid_i) begin
         next_partner = rx_page_i;
      end
      next_adv.page = {9'h000, act10, selector};
      next_adv.gig_fd = forced && ctrl.duplex;
      next_adv.gig_hd = forced && !ctrl.duplex;
      next_adv.aneg_on = ctrl.aneg_en || forced;
      if (forced) begin
         next_adv.page[aneg_regs_pkg::ADV_TECH_HI:aneg_regs_pkg::ADV_TECH_LO] = 4'h0;
      end
      if (rst_i) begin
         next_ctrl = '0;
         next_ctrl.aneg_en = aneg_regs_pkg::ANEG_EN_RESET;
         next_pend10 = {2{strap_sync[aneg_regs_pkg::STRAP_10_BIT]}};
         next_act10 = {2{strap_sync[aneg_regs_pkg::STRAP_10_BIT]}};
         next_selector = aneg_regs_pkg::SEL_RESET;
         next_partner = aneg_regs_pkg::PART_RESET;
         next_link_q = 1'b0;
         next_ack = 1'b0;
         next_dat = 32'h0000_0000;
         next_adv = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (ce_i) begin
         ctrl <= next_ctrl;
         pend10 <= next_pend10;
         act10 <= next_act10;
         selector <= next_selector;
         partner <= next_partner;
         link_q <= next_link_q;
         ack_o <= next_ack;
         dat_o <= next_dat;
         adv_o <= next_adv;
      end
   end

   // bus handshake steps
   sequence bus_req_s;
      ce_i && cyc_i && stb_i && !ack_o;
   endsequence

   sequence bus_idle_s;
      ce_i && !(cyc_i && stb_i);
   endsequence

   sequence adv_write_s;
      ce_i && wr && idx == aneg_regs_pkg::IDX_ADV && sel_i[0];
   endsequence

   // copper link seen up, then seen down on the next edge
   sequence link_drop_s;
      ce_i && link_up_i ##1 ce_i && !link_up_i;
   endsequence

   // last reset edge followed by the first running edge
   sequence reset_release_s;
      ce_i && rst_i ##1 ce_i && !rst_i;
   endsequence

   // bus handshake
   bus_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_req_s |=> ack_o)
      else $error("wishbone request not acknowledged in one cycle");

   ack_drop_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && ack_o |=> !ack_o)
      else $error("ack held longer than one cycle");

   ack_idle_a: assert property (@(posedge clk_i) disable iff (rst_i)
      bus_idle_s |=> !ack_o)
      else $error("ack given without a request");

   ack_reset_a: assert property (@(posedge clk_i)
      ce_i && rst_i |=> !ack_o)
      else $error("ack not cleared by reset");

   read_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && ack_o |-> dat_o[31:16] == 16'h0000)
      else $error("read data upper half not zero");

   // deferred advertise bits
   write_defer_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !apply |=> act10 == $past(act10))
      else $error("advertise write took effect without an apply event");

   adv_pend_a: assert property (@(posedge clk_i) disable iff (rst_i)
      adv_write_s |=> pend10 == {$past(dat_i[aneg_regs_pkg::ADV_10FD_BIT]),
         $past(dat_i[aneg_regs_pkg::ADV_10HD_BIT])})
      else $error("advertise write not held as pending");

   pending_apply_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && apply |=> act10 == $past(pend10))
      else $error("pending advertise value not applied");

   link_apply_a: assert property (@(posedge clk_i) disable iff (rst_i)
      link_drop_s |=> act10 == $past(pend10))
      else $error("link loss did not apply the pending advertisement");

   sw_apply_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && sw_rst_evt |=> act10 == $past(pend10))
      else $error("software reset did not apply the pending advertisement");

   // forced 1000 advertisement
   forced_gig_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && forced |=> adv_o.aneg_on && adv_o.gig_fd == $past(ctrl.duplex)
         && adv_o.gig_hd == !$past(ctrl.duplex))
      else $error("forced 1000 advertisement wrong");

   unforced_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !forced |=> !adv_o.gig_fd && !adv_o.gig_hd
         && adv_o.aneg_on == $past(ctrl.aneg_en))
      else $error("gigabit-only advertisement outside forced 1000");

   forced_mask_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && forced
         |=> adv_o.page[aneg_regs_pkg::ADV_TECH_HI:aneg_regs_pkg::ADV_TECH_LO] == 4'h0)
      else $error("10/100 bits advertised in forced 1000");

   adv_page_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !forced
         |=> adv_o.page[aneg_regs_pkg::ADV_10FD_BIT:aneg_regs_pkg::ADV_10HD_BIT] == $past(act10)
         && adv_o.page[aneg_regs_pkg::SEL_HI:0] == $past(selector))
      else $error("advertised page does not follow active bits");

   adv_reset_a: assert property (@(posedge clk_i)
      ce_i && rst_i |=> adv_o == '0)
      else $error("advertisement output not cleared by reset");

   // strap and selector
   strap_load_a: assert property (@(posedge clk_i)
      reset_release_s |-> pend10 == {2{$past(strap_sync[aneg_regs_pkg::STRAP_10_BIT])}}
         && act10 == {2{$past(strap_sync[aneg_regs_pkg::STRAP_10_BIT])}})
      else $error("advertise bits did not load from strap");

   sel_reset_a: assert property (@(posedge clk_i)
      ce_i && rst_i |=> selector == aneg_regs_pkg::SEL_RESET)
      else $error("selector reset value wrong");

   sel_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && sw_rst_evt |=> selector == $past(selector))
      else $error("selector changed on software reset");

   sel_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
      adv_write_s |=> selector == $past(dat_i[aneg_regs_pkg::SEL_HI:0]))
      else $error("selector write not taken");

   // partner ability
   partner_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && sw_rst_evt && !page_valid_i |=> partner == aneg_regs_pkg::PART_RESET)
      else $error("partner ability not cleared by software reset");

   partner_reset_a: assert property (@(posedge clk_i)
      ce_i && rst_i |=> partner == aneg_regs_pkg::PART_RESET)
      else $error("partner ability not cleared by hardware reset");

   partner_ro_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && wr && idx == aneg_regs_pkg::IDX_PART && !page_valid_i && !sw_rst_evt
         |=> partner == $past(partner))
      else $error("partner ability changed by a write");

   partner_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && !page_valid_i && !sw_rst_evt |=> partner == $past(partner))
      else $error("partner ability changed without a page");

   page_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && page_valid_i |=> partner == $past(rx_page_i))
      else $error("received page not captured whole");

endmodule

// ### tb/link_partner_model.sv
// far-side transceiver model: sends base pages and reports copper link state
`timescale 1ns/100ps
module link_partner_model (
   input wire logic clk_i,
   input wire logic send_i,
   input wire logic [15:0] word_i,
   input wire logic link_i,
   output logic page_valid_o,
   output logic [15:0] rx_page_o,
   output logic link_up_o
);
   initial begin
      page_valid_o = 1'b0;
      rx_page_o = 16'h0000;
      link_up_o = 1'b1;
   end
   // outside a page the word lines keep toggling so stale data never looks valid
   always @(posedge clk_i) begin
      page_valid_o <= send_i;
      rx_page_o <= send_i ? word_i : ~rx_page_o;
      link_up_o <= link_i;
   end
endmodule

// ### tb/tb.sv
// self-checking bench for the base-page register bank
`timescale 1ns/100ps
module tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, send = 1'b0, link = 1'b1;
   logic ack_o, page_valid, link_up;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h00000000, rdat, dat_o;
   logic [15:0] rx_page, word = 16'h0000;
   logic [1:0] strap = 2'h2;
   logic [3:0] sel = 4'h0;
   aneg_regs_pkg::adv_out_t adv_o;
   int failures = 0, num_checks = 0;
   logic [15:0] pages [12] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'h0400,
      16'h0200, 16'h0100, 16'h0080, 16'h0040, 16'h0020, 16'hA5C3};
   always #50 clk_i = ~clk_i;
   copper_aneg_base_page_regs uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(dat_o),
      .ack_o(ack_o), .negotiation_config_strap_i(strap), .link_up_i(link_up),
      .page_valid_i(page_valid), .rx_page_i(rx_page), .adv_o(adv_o));
   link_partner_model partner (.clk_i(clk_i), .send_i(send), .word_i(word), .link_i(link),
      .page_valid_o(page_valid), .rx_page_o(rx_page), .link_up_o(link_up));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= 4'h3;
      adr <= a;
      wdat <= {16'h0000, d};
      // only the watchdog ends a wait that never sees ack
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      wb(1'b0, a, 16'h0000);
      chk(rdat, {16'h0000, exp});
   endtask
   // adv_o follows a committed write one edge later
   task automatic adv_chk(input logic [18:0] exp);
      repeat (3) @(posedge clk_i);
      chk({13'h0000, adv_o}, {13'h0000, exp});
   endtask
   task automatic send_page(input logic [15:0] w);
      @(posedge clk_i);
      send <= 1'b1;
      word <= w;
      @(posedge clk_i);
      send <= 1'b0;
      repeat (2) @(posedge clk_i);
   endtask
   task automatic hw_reset();
      rst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
   endtask
   task automatic print_verdict();
      if (failures == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      #1000000;
      failures++;
      print_verdict();
   end
   initial begin
      hw_reset();
      rd(8'h10, 16'h0061);
      rd(8'h14, 16'h0000);
      adv_chk({16'h0061, 3'b001});
      wb(1'b1, 8'h10, 16'h000A);
      rd(8'h10, 16'h000A);
      adv_chk({16'h006A, 3'b001});
      wb(1'b1, 8'h00, 16'h1200);
      adv_chk({16'h000A, 3'b001});
      wb(1'b1, 8'h00, 16'h1800);
      wb(1'b1, 8'h10, 16'h0041);
      adv_chk({16'h0001, 3'b001});
      wb(1'b1, 8'h00, 16'h1000);
      adv_chk({16'h0041, 3'b001});
      wb(1'b1, 8'h10, 16'h0061);
      adv_chk({16'h0041, 3'b001});
      @(posedge clk_i);
      link <= 1'b0;
      // link loss passes the partner model flop first, then applies on the edge that clears the link register
      @(posedge clk_i);
      adv_chk({16'h0061, 3'b001});
      link <= 1'b1;
      wb(1'b1, 8'h00, 16'h0140);
      adv_chk({16'h0001, 3'b101});
      wb(1'b1, 8'h00, 16'h0040);
      adv_chk({16'h0001, 3'b011});
      wb(1'b1, 8'h00, 16'h1000);
      adv_chk({16'h0061, 3'b001});
      foreach (pages[i]) begin
         send_page(pages[i]);
         rd(8'h14, pages[i]);
      end
      wb(1'b1, 8'h14, 16'hFFFF);
      rd(8'h14, 16'hA5C3);
      wb(1'b1, 8'h3C, 16'hFFFF);
      rd(8'h3C, 16'h0000);
      wb(1'b1, 8'h10, 16'h0028);
      wb(1'b1, 8'h00, 16'h9000);
      rd(8'h14, 16'h0000);
      rd(8'h10, 16'h0028);
      adv_chk({16'h0028, 3'b001});
      strap <= 2'h1;
      hw_reset();
      rd(8'h10, 16'h0001);
      print_verdict();
   end
endmodule
